// ===== shared/sadc_pkg.sv
/*
  Shared constants and types for the SAR converter readout block.
  Assumes a 200 MHz core clock and a serial clock that only runs while
  the host reads a result.
*/
package sadc_pkg;

  // ==========================================================
  // widths and codes
  localparam int RES_W = 16;
  localparam int IDX_W = 5;
  localparam int STEP_W = 4;
  localparam logic [IDX_W-1:0] IDX_ZERO = 5'h00;
  localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;
  localparam logic [IDX_W-1:0] IDX_PLAIN_END = 5'h10;
  localparam logic [IDX_W-1:0] IDX_BUSY_END = 5'h11;
  localparam logic [IDX_W-1:0] IDX_TOP = 5'h0F;
  localparam logic [IDX_W-1:0] IDX_BUSY_TOP = 5'h10;
  localparam logic [RES_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [RES_W-1:0] SIGN_FLIP = 16'h8000;
  localparam logic [RES_W-1:0] SAR_MSB = 16'h8000;
  localparam logic [RES_W-1:0] SAR_LSB = 16'h0001;
  localparam logic [STEP_W-1:0] STEP_ZERO = 4'h0;

  // ==========================================================
  // conversion timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_CONV_MIN_NS = 500;
  localparam int T_CONV_MAX_NS = 710;
  localparam int STEP_CYCLES =
    (T_CONV_MIN_NS + RES_W * CLK_PERIOD_NS - 1) / (RES_W * CLK_PERIOD_NS);
  localparam int CONV_CYCLES = RES_W * STEP_CYCLES;
  localparam int CONV_MIN_CYCLES = (T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES = T_CONV_MAX_NS / CLK_PERIOD_NS;
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

  // ==========================================================
  // types
  typedef enum logic {SADC_MODE_CS, SADC_MODE_CHAIN} sadc_mode_t;
  typedef enum logic {SADC_ACQ, SADC_CONV} sadc_phase_t;

endpackage : sadc_pkg

// ===== shared/sadc_if.sv
/*
  Carrier between the core controller, the SAR engine and the
  serial-clock edge counter. Holds no logic of its own.
*/
`timescale 1ns/1ps
interface sadc_if;
  import sadc_pkg::*;
  logic             conv_start;
  logic [RES_W-1:0] conv_target;
  logic             conv_done;
  logic             conv_active;
  logic [RES_W-1:0] conv_code;
  logic [IDX_W-1:0] link_gray;

  modport ctrl (output conv_start, output conv_target, input conv_done,
                input conv_active, input conv_code, input link_gray);
  modport sar  (input conv_start, input conv_target, output conv_done,
                output conv_active, output conv_code);
  modport link (output link_gray);
endinterface : sadc_if

// ===== hdl/sadc_sar.sv
/*
  Successive approximation engine on the core clock.
  Assumes start is a one-cycle pulse and target is stable with it.
*/
`timescale 1ns/1ps
module sadc_sar
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller side
  sadc_if.sar      conv
);
  logic              active;
  logic              done;
  logic [STEP_W-1:0] step;
  logic [RES_W-1:0]  mask;
  logic [RES_W-1:0]  code;
  logic [RES_W-1:0]  target;
  int unsigned       run_cnt;

  // ==========================================================
  // bit trials, one every STEP_CYCLES; start ignored while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      step   <= STEP_ZERO;
      mask   <= CODE_ZERO;
      code   <= CODE_ZERO;
      target <= CODE_ZERO;
    end else if (conv.conv_start && !active) begin
      active <= 1'b1;
      step   <= STEP_ZERO;
      mask   <= SAR_MSB;
      code   <= CODE_ZERO;
      target <= conv.conv_target;
    end else if (active) begin
      if (step == STEP_LAST) begin
        step <= STEP_ZERO;
        mask <= mask >> 1;
        if ((code | mask) <= target) begin
          code <= code | mask;
        end
        if (mask == SAR_LSB) begin
          active <= 1'b0;
        end
      end else begin
        step <= step + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= active && (step == STEP_LAST) && (mask == SAR_LSB);
    end
  end

  assign conv.conv_done   = done;
  assign conv.conv_active = active;
  assign conv.conv_code   = code;

  // ==========================================================
  // checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 0;
    end else if (conv.conv_start && !active) begin
      run_cnt <= 0;
    end else if (active) begin
      run_cnt <= run_cnt + 1;
    end
  end

  property p_conv_time;
    @(posedge clk) disable iff (!rst_n)
      done |-> (run_cnt >= CONV_MIN_CYCLES) && (run_cnt <= CONV_MAX_CYCLES);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion time outside bounds");

  property p_sar_exact;
    @(posedge clk) disable iff (!rst_n)
      done |-> (code == target);
  endproperty
  a_sar_exact: assert property (p_sar_exact)
    else $error("converted code differs from sampled value");
endmodule : sadc_sar

// ===== hdl/sadc_link.sv
/*
  Serial-clock domain: counts falling edges of the read clock within
  one select frame and publishes the count in gray code.
  Assumes the select pin is high between frames; that level clears it.
*/
`timescale 1ns/1ps
module sadc_link
  import sadc_pkg::*;
(
  // link clock and frame clear
  input wire logic sclk,
  input wire logic frame_clear,
  // to the core
  sadc_if.link     lnk
);
  logic [IDX_W-1:0] cnt;
  logic [IDX_W-1:0] next_cnt;
  logic [IDX_W-1:0] gray;
  logic [IDX_W-1:0] prev_gray;

  // saturate so a long burst cannot wrap back into the data bits
  always_comb begin
    next_cnt = (cnt == IDX_BUSY_END) ? cnt : cnt + 1'b1;
  end

  // ==========================================================
  // frame counter; the clock may stop, so the frame level clears it
  always_ff @(negedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      cnt       <= IDX_ZERO;
      gray      <= IDX_ZERO;
      prev_gray <= IDX_ZERO;
    end else begin
      cnt       <= next_cnt;
      gray      <= next_cnt ^ (next_cnt >> 1);
      prev_gray <= gray;
    end
  end

  assign lnk.link_gray = gray;

  // compare within one frame only; the clear resets both copies
  property p_gray_step;
    @(negedge sclk) disable iff (frame_clear)
      $countones(gray ^ prev_gray) <= 1;
  endproperty
  a_gray_step: assert property (p_gray_step)
    else $error("gray count moved more than one bit");
endmodule : sadc_link

// ===== hdl/sadc_top.sv
/*
  Conversion control and serial readout of a 16-bit SAR converter.
  Assumes the host drives the start/select pin, the mode input and the
  read clock asynchronously to CORE_CLK, and resolves the output pin
  from SER_DATA_OUT and SER_DATA_OUT_OE.
*/
`timescale 1ns/1ps
module sadc_top
  import sadc_pkg::*;
(
  // core clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST_N,
  // serial link pins
  input  wire logic             SCLK,
  input  wire logic             CONVERT_START_SELECT,
  input  wire logic             MODE_DATA_IN,
  output logic                  SER_DATA_OUT,
  output logic                  SER_DATA_OUT_OE,
  // sampled input pair, as unsigned levels
  input  wire logic [RES_W-1:0] AIN_POS,
  input  wire logic [RES_W-1:0] AIN_NEG,
  // status
  output logic                  CONV_ACTIVE,
  output logic                  CORE_POWER_DOWN,
  output logic                  MODE_CHAIN,
  output logic                  BUSY_BIT_SENT
);
  sadc_if bus ();

  // ==========================================================
  // synchronisers
  logic             cs_s1;
  logic             cs_s2;
  logic             cs_s3;
  logic             din_s1;
  logic             din_s2;
  logic [RES_W-1:0] ainp_s1;
  logic [RES_W-1:0] ainp_s2;
  logic [RES_W-1:0] ainn_s1;
  logic [RES_W-1:0] ainn_s2;
  logic [IDX_W-1:0] gray_s1;
  logic [IDX_W-1:0] gray_s2;
  logic [IDX_W-1:0] gray_s3;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      cs_s1  <= CONVERT_START_SELECT;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      din_s1 <= MODE_DATA_IN;
      din_s2 <= din_s1;
    end
  end

  // analog levels are held by the front end; registered every cycle, captured into target only on a start
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ainp_s1 <= CODE_ZERO;
      ainp_s2 <= CODE_ZERO;
      ainn_s1 <= CODE_ZERO;
      ainn_s2 <= CODE_ZERO;
    end else begin
      ainp_s1 <= AIN_POS;
      ainp_s2 <= ainp_s1;
      ainn_s1 <= AIN_NEG;
      ainn_s2 <= ainn_s1;
    end
  end

  // gray count changes one bit per read clock, so two flops suffice;
  // a third lets the select level win over the count's async clear
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gray_s1 <= IDX_ZERO;
      gray_s2 <= IDX_ZERO;
      gray_s3 <= IDX_ZERO;
    end else begin
      gray_s1 <= bus.link_gray;
      gray_s2 <= gray_s1;
      gray_s3 <= gray_s2;
    end
  end

  // ==========================================================
  // edge and index decode
  logic             cs_rise;
  wire  [IDX_W-1:0] idx;

  assign cs_rise = cs_s2 && !cs_s3;
  assign idx[IDX_W-1] = gray_s3[IDX_W-1];

  // gray to binary, top bit down
  for (genvar gi = IDX_W - 2; gi >= 0; gi--) begin : g_gray_dec
    assign idx[gi] = idx[gi+1] ^ gray_s3[gi];
  end

  // ==========================================================
  // start of conversion
  sadc_phase_t      phase;
  sadc_mode_t       mode;
  logic             start;
  logic [RES_W-1:0] target;
  logic [RES_W:0]   diff;

  // signed difference halved keeps the full +-ref swing in 16 bits
  assign diff = {1'b0, ainp_s2} - {1'b0, ainn_s2};

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start  <= 1'b0;
      target <= CODE_ZERO;
    end else begin
      start <= cs_rise && (phase == SADC_ACQ);
      if (cs_rise && (phase == SADC_ACQ)) begin
        target <= diff[RES_W:1] ^ SIGN_FLIP;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode <= SADC_MODE_CS;
    end else if (cs_rise && (phase == SADC_ACQ)) begin
      mode <= din_s2 ? SADC_MODE_CS : SADC_MODE_CHAIN;
    end
  end

  assign bus.conv_start  = start;
  assign bus.conv_target = target;

  // ==========================================================
  // phase: a start edge during a conversion is ignored
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase <= SADC_ACQ;
    end else begin
      unique case (phase)
        SADC_ACQ: begin
          if (cs_rise) begin
            phase <= SADC_CONV;
          end
        end
        SADC_CONV: begin
          if (bus.conv_done) begin
            phase <= SADC_ACQ;
          end
        end
      endcase
    end
  end

  sadc_sar u_sar (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .conv  (bus.sar)
  );

  // ==========================================================
  // result capture and busy-bit decision at conversion end
  logic [RES_W-1:0] result;
  logic             have_result;
  logic             busy_sel;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      result      <= CODE_ZERO;
      have_result <= 1'b0;
      busy_sel    <= 1'b0;
    end else if (bus.conv_done) begin
      result      <= bus.conv_code ^ SIGN_FLIP;
      have_result <= 1'b1;
      busy_sel    <= (mode == SADC_MODE_CS) && !cs_s2;
    end
  end

  // ==========================================================
  // serial read clock domain
  logic link_clear;

  // select high clears the counter even while the read clock is still
  assign link_clear = CONVERT_START_SELECT || !RST_N;

  sadc_link u_link (
    .sclk        (SCLK),
    .frame_clear (link_clear),
    .lnk         (bus.link)
  );

  // ==========================================================
  // output pin drive
  logic             next_oe;
  logic             next_bit;
  logic [IDX_W-1:0] frame_end;
  logic [IDX_W-1:0] pos;
  logic             dout;
  logic             dout_oe;

  assign frame_end = busy_sel ? IDX_BUSY_END : IDX_PLAIN_END;

  always_comb begin
    next_oe  = (phase == SADC_ACQ) && have_result && !cs_s2
               && (idx < frame_end);
    pos      = busy_sel ? (IDX_BUSY_TOP - idx) : (IDX_TOP - idx);
    next_bit = 1'b0;
    if (next_oe) begin
      if (busy_sel && (idx == IDX_ZERO)) begin
        next_bit = 1'b0;
      end else begin
        next_bit = result[pos[IDX_W-2:0]];
      end
    end
  end

  // output lags the pin by the synchroniser depth plus this register, about 20 ns
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout    <= next_bit;
      dout_oe <= next_oe;
    end
  end

  assign SER_DATA_OUT    = dout;
  assign SER_DATA_OUT_OE = dout_oe;
  assign CONV_ACTIVE     = (phase == SADC_CONV);
  assign CORE_POWER_DOWN = (phase == SADC_ACQ);
  assign MODE_CHAIN      = (mode == SADC_MODE_CHAIN);
  assign BUSY_BIT_SENT   = busy_sel;

  // ==========================================================
  // checks
  property p_mode_cs;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (cs_rise && (phase == SADC_ACQ) && din_s2) |=> (mode == SADC_MODE_CS);
  endproperty
  a_mode_cs: assert property (p_mode_cs)
    else $error("high mode input did not select chip-select mode");

  property p_mode_chain;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (cs_rise && (phase == SADC_ACQ) && !din_s2) |=> (mode == SADC_MODE_CHAIN);
  endproperty
  a_mode_chain: assert property (p_mode_chain)
    else $error("low mode input did not select daisy-chain mode");

  property p_busy_first;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((phase == SADC_ACQ) && have_result && busy_sel && !cs_s2 && (idx == IDX_ZERO))
        |=> (dout_oe && !dout);
  endproperty
  a_busy_first: assert property (p_busy_first)
    else $error("busy bit not driven low ahead of data");

  property p_read_in_acq;
    @(posedge CORE_CLK) disable iff (!RST_N)
      dout_oe |-> (phase == SADC_ACQ) && have_result;
  endproperty
  a_read_in_acq: assert property (p_read_in_acq)
    else $error("output driven outside acquisition");

  property p_start_edge;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (cs_rise && (phase == SADC_ACQ)) |=> (!dout_oe && (phase == SADC_CONV)) ##1 bus.conv_active;
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start edge did not release output and convert");

  property p_conv_holds;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((phase == SADC_CONV) && !bus.conv_done) |=> (phase == SADC_CONV);
  endproperty
  a_conv_holds: assert property (p_conv_holds)
    else $error("conversion abandoned before completion");

  property p_no_busy;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (bus.conv_done && cs_s2) |=> !busy_sel;
  endproperty
  a_no_busy: assert property (p_no_busy)
    else $error("busy bit armed although start was high");

  property p_power_down;
    @(posedge CORE_CLK) disable iff (!RST_N)
      bus.conv_done |=> CORE_POWER_DOWN && !CONV_ACTIVE && have_result;
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("converter not powered down after conversion");

  property p_msb_first;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((phase == SADC_ACQ) && have_result && !busy_sel && !cs_s2 && (idx == IDX_ZERO))
        |=> (dout_oe && (dout == result[RES_W-1]));
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("most significant bit not driven first");

  property p_second_bit;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (next_oe && !busy_sel && (idx == IDX_ONE)) |=> (dout == result[RES_W-2]);
  endproperty
  a_second_bit: assert property (p_second_bit)
    else $error("second bit wrong after first falling edge");

  property p_release;
    @(posedge CORE_CLK) disable iff (!RST_N)
      ((idx >= frame_end) || cs_s2) |=> !dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output still driven after frame end");

  property p_start_pulse;
    @(posedge CORE_CLK) disable iff (!RST_N)
      bus.conv_start |=> !bus.conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start request held longer than one cycle");

  property p_no_restart;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (cs_rise && (phase == SADC_CONV)) |=> !bus.conv_start;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("start edge during conversion restarted it");

  property p_mode_kept;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (phase == SADC_CONV) |=> $stable(mode);
  endproperty
  a_mode_kept: assert property (p_mode_kept)
    else $error("mode changed during conversion");

  property p_quiet_low;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !dout_oe |-> !dout;
  endproperty
  a_quiet_low: assert property (p_quiet_low)
    else $error("data driven while output released");

endmodule : sadc_top

// ===== tb/sadc_host.sv
/*
  Host model for the converter readout: drives the start/select pin,
  the mode input and the read clock, and captures the serial bits.
  Assumes a pull-up on the data line and the core clock for pin timing.
*/
`timescale 1ns/1ps
module sadc_host (
  // pin timing reference
  input  wire logic clk,
  // data line from the converter
  input  wire logic dout,
  input  wire logic dout_oe,
  // host-driven pins
  output logic      start_sel,
  output logic      mode,
  output logic      sclk
);
  // ==========================================================
  // line and capture
  // pull-up: a released line reads high, never the last bit
  wire logic   line_lvl = dout_oe ? dout : 1'b1;
  logic [16:0] got;

  initial begin
    start_sel = 1'b1;
    mode      = 1'b1;
    sclk      = 1'b0;
    got       = 17'h00000;
  end

  // idle long enough for any pending conversion, then a fresh start edge
  task automatic start(input logic m);
    @(posedge clk);
    mode <= m;
    repeat (150) @(posedge clk);
    start_sel <= 1'b0;
    repeat (4) @(posedge clk);
    start_sel <= 1'b1;
  endtask : start

  task automatic lower;
    @(posedge clk);
    start_sel <= 1'b0;
  endtask : lower

  task automatic raise;
    @(posedge clk);
    start_sel <= 1'b1;
  endtask : raise

  // read clock runs only inside the frame; idle level low
  task automatic clock_out(input int n);
    got = 17'h00000;
    #31;
    repeat (n) begin
      sclk = 1'b1;
      got = {got[15:0], line_lvl};
      #24;
      sclk = 1'b0;
      #24;
    end
  endtask : clock_out
endmodule : sadc_host

// ===== tb/test_sadc_top.sv
/*
  Self-checking bench for the converter readout block.
  Assumes the host model drives all link pins; bench owns inputs.
*/
`timescale 1ns/1ps
module test_sadc_top;
  import sadc_pkg::*;
  logic             CORE_CLK;
  logic             RST_N;
  logic [RES_W-1:0] AIN_POS;
  logic [RES_W-1:0] AIN_NEG;
  logic             SCLK;
  logic             CONVERT_START_SELECT;
  logic             MODE_DATA_IN;
  logic             SER_DATA_OUT;
  logic             SER_DATA_OUT_OE;
  logic             CONV_ACTIVE;
  logic             CORE_POWER_DOWN;
  logic             MODE_CHAIN;
  logic             BUSY_BIT_SENT;
  int               failures;
  int               checks_done;
  int               cycles;
  logic [15:0]      pos_tab [4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h1235};
  logic [15:0]      neg_tab [4] = '{16'h0000, 16'hFFFF, 16'h8001, 16'h0F0F};

  sadc_top uut (
    .CORE_CLK             (CORE_CLK),
    .RST_N                (RST_N),
    .SCLK                 (SCLK),
    .CONVERT_START_SELECT (CONVERT_START_SELECT),
    .MODE_DATA_IN         (MODE_DATA_IN),
    .SER_DATA_OUT         (SER_DATA_OUT),
    .SER_DATA_OUT_OE      (SER_DATA_OUT_OE),
    .AIN_POS              (AIN_POS),
    .AIN_NEG              (AIN_NEG),
    .CONV_ACTIVE          (CONV_ACTIVE),
    .CORE_POWER_DOWN      (CORE_POWER_DOWN),
    .MODE_CHAIN           (MODE_CHAIN),
    .BUSY_BIT_SENT        (BUSY_BIT_SENT)
  );

  sadc_host host (
    .clk       (CORE_CLK),
    .dout      (SER_DATA_OUT),
    .dout_oe   (SER_DATA_OUT_OE),
    .start_sel (CONVERT_START_SELECT),
    .mode      (MODE_DATA_IN),
    .sclk      (SCLK)
  );

  // ==========================================================
  // clock, timeout, reporting
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // halved difference, two's complement
  function automatic logic [15:0] expect_code(input logic [15:0] p, input logic [15:0] n);
    logic [16:0] d;
    d = {1'b0, p} - {1'b0, n};
    return d[16:1];
  endfunction : expect_code

  // counts active cycles; sampled on the falling edge, away from updates
  task automatic wait_conv(output int n);
    n = 0;
    for (int i = 0; i < 150; i++) begin
      @(negedge CORE_CLK);
      if (CONV_ACTIVE === 1'b1) n++;
      if (i == 6) check(SER_DATA_OUT_OE, 1'b0);
      if (i == 6) check(CORE_POWER_DOWN, 1'b0);
    end
  endtask : wait_conv

  task automatic set_ain(input logic [15:0] p, input logic [15:0] n);
    @(posedge CORE_CLK);
    AIN_POS <= p;
    AIN_NEG <= n;
  endtask : set_ain

  // ==========================================================
  // scenarios
  task automatic test_chain;
    int n;
    set_ain(16'h1000, 16'h3000);
    host.start(1'b0);
    wait_conv(n);
    check(MODE_CHAIN, 1'b1);
    host.lower();
    host.clock_out(16);
    check(host.got[15:0], expect_code(16'h1000, 16'h3000));
    host.raise();
    $display("test_chain done");
  endtask : test_chain

  task automatic test_cs_read;
    int n;
    for (int k = 0; k < 4; k++) begin
      set_ain(pos_tab[k], neg_tab[k]);
      host.start(1'b1);
      wait_conv(n);
      check(n >= CONV_MIN_CYCLES && n <= CONV_MAX_CYCLES, 1'b1);
      check(CORE_POWER_DOWN, 1'b1);
      check(MODE_CHAIN, 1'b0);
      check(BUSY_BIT_SENT, 1'b0);
      host.lower();
      host.clock_out(16);
      check(host.got[15:0], expect_code(pos_tab[k], neg_tab[k]));
      repeat (6) @(negedge CORE_CLK);
      check(SER_DATA_OUT_OE, 1'b0);
      host.raise();
    end
    $display("test_cs_read done");
  endtask : test_cs_read

  // start line toggles mid-conversion; inputs change after sampling
  task automatic test_hold;
    set_ain(16'h4000, 16'h0100);
    host.start(1'b1);
    repeat (10) @(posedge CORE_CLK);
    host.lower();
    AIN_POS <= 16'h0000;
    repeat (10) @(negedge CORE_CLK);
    check(SER_DATA_OUT_OE, 1'b0);
    host.raise();
    repeat (150) @(negedge CORE_CLK);
    host.lower();
    host.clock_out(16);
    check(host.got[15:0], expect_code(16'h4000, 16'h0100));
    host.raise();
    $display("test_hold done");
  endtask : test_hold

  task automatic test_release;
    logic [15:0] e;
    // top bits mix ones and zeros, so a released line cannot pass
    set_ain(16'h0000, 16'h5000);
    e = expect_code(16'h0000, 16'h5000);
    host.start(1'b1);
    repeat (150) @(negedge CORE_CLK);
    host.lower();
    host.clock_out(5);
    check(host.got[4:0], e[15:11]);
    host.raise();
    repeat (6) @(negedge CORE_CLK);
    check(SER_DATA_OUT_OE, 1'b0);
    $display("test_release done");
  endtask : test_release

  task automatic test_busy;
    set_ain(16'hC350, 16'h2222);
    host.start(1'b1);
    repeat (20) @(posedge CORE_CLK);
    host.lower();
    repeat (150) @(negedge CORE_CLK);
    check(BUSY_BIT_SENT, 1'b1);
    check({SER_DATA_OUT_OE, SER_DATA_OUT}, 2'b10);
    host.clock_out(17);
    check(host.got, {1'b0, expect_code(16'hC350, 16'h2222)});
    repeat (6) @(negedge CORE_CLK);
    check(SER_DATA_OUT_OE, 1'b0);
    host.raise();
    $display("test_busy done");
  endtask : test_busy

  initial begin
    failures = 0;
    checks_done = 0;
    cycles = 0;
    RST_N = 1'b0;
    AIN_POS = 16'h0000;
    AIN_NEG = 16'h0000;
    repeat (9) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    check({SER_DATA_OUT_OE, SER_DATA_OUT, CONV_ACTIVE}, 3'b000);
    check({CORE_POWER_DOWN, MODE_CHAIN, BUSY_BIT_SENT}, 3'b100);
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    test_chain();
    test_cs_read();
    test_hold();
    test_release();
    test_busy();
    end_of_test();
  end
endmodule : test_sadc_top
